// >>> logic/bobse_pkg.sv
// constants and types shared by the byte-op, branch and skip execution core
package bobse_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PC_W = 11;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RESET = 12'h000;

  // ****************************************
  // field positions
  // ****************************************
  localparam logic [FILE_AW-1:0] STATUS_ADDR = 5'h03;
  localparam int Z_BIT = 2;
  localparam int PAGE_LO = 5;
  localparam int PAGE_HI = 6;
  localparam int DEST_BIT = 5;
  localparam int JUMP_K_W = 9;
  localparam int SQUASH_IDX = 1;

  // ****************************************
  // instruction codes and masks
  // ****************************************
  localparam logic [INSTR_W-1:0] MASK_FD = 12'hfc0;
  localparam logic [INSTR_W-1:0] MASK_F = 12'hfe0;
  localparam logic [INSTR_W-1:0] MASK_JUMP = 12'he00;
  localparam logic [INSTR_W-1:0] MASK_LIT = 12'hf00;
  localparam logic [INSTR_W-1:0] OP_DEC_SKIP = 12'h2c0;
  localparam logic [INSTR_W-1:0] OP_INC_SKIP = 12'h3c0;
  localparam logic [INSTR_W-1:0] OP_OR_FILE = 12'h100;
  localparam logic [INSTR_W-1:0] OP_COPY_FILE = 12'h200;
  localparam logic [INSTR_W-1:0] OP_STORE_ACC = 12'h020;
  localparam logic [INSTR_W-1:0] OP_JUMP = 12'ha00;
  localparam logic [INSTR_W-1:0] OP_OR_LIT = 12'hd00;

  // ****************************************
  // pipeline states
  // ****************************************
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_SQUASH = 2'b10
  } bobse_state_t;

endpackage

// >>> logic/bobse_file_mem.sv
// file register storage with registered, write-through read port
`timescale 1ns/1ps
module bobse_file_mem
#(
  parameter int AW = 5,
  parameter int DW = 8
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);

  // ****************************************
  // parameter check
  // ****************************************
  if (AW < 1 || AW > 8 || DW < 1)
  begin : g_bad_size
    $error("file memory size not supported");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] cells;
    logic [DW-1:0] rd;
  } bobse_mem_st_t;

  bobse_mem_st_t r;
  bobse_mem_st_t n;

  // write, then read with bypass so a just-written value is seen
  always_comb
  begin
    n = r;
    if (ce_in)
    begin
      if (wr_en_in)
        n.cells[wr_addr_in] = wr_data_in;
      n.rd = n.cells[rd_addr_in];
    end
  end

  // register the state
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      r <= '0;
    else
      r <= n;
  end

  assign rd_data_out = r.rd;

endmodule

// >>> logic/bobse_core.sv
// execution core for skip, jump, or, store and copy instructions
//
// Notes on behaviour
// - destination bit picks accumulator or file register
// - decrement, no flags, zero result squashes next
// - increment, no flags, zero result squashes next
// - jump: immediate to low bits, page bits high
// - jump takes two cycles, flags untouched
// - or literal into accumulator, zero flag updated
// - or accumulator with file, zero flag updated
// - store accumulator to any file address, flags kept except when the address is status
// - copy file register, zero flag updated, tests
`timescale 1ns/1ps
module bobse_core
  import bobse_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [bobse_pkg::INSTR_W-1:0] instr_in,
  output logic [bobse_pkg::PC_W-1:0] program_counter_out,
  output logic [bobse_pkg::DATA_W-1:0] acc_out,
  output logic [bobse_pkg::DATA_W-1:0] status_out,
  output logic [bobse_pkg::INSTR_W-1:0] exec_instr_out,
  output logic squash_out
);
  import bobse_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    bobse_state_t state;
    logic [INSTR_W-1:0] instr;
    logic [PC_W-1:0] program_counter;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] status;
  } bobse_core_st_t;

  localparam bobse_core_st_t CORE_RESET = '{
    state: ST_SQUASH,
    instr: INSTR_RESET,
    program_counter: PC_RESET,
    acc: ACC_RESET,
    status: STATUS_RESET
  };

  bobse_core_st_t r;
  bobse_core_st_t n;

  logic [DATA_W-1:0] mem_rd;
  logic [FILE_AW-1:0] fsel;
  logic dest_file;
  logic [DATA_W-1:0] fval;
  logic is_dec;
  logic is_inc;
  logic is_or_file;
  logic is_copy;
  logic is_store;
  logic is_jump;
  logic is_or_lit;
  logic [DATA_W-1:0] result;
  logic wr_acc;
  logic wr_file;
  logic upd_z;
  logic skip;
  logic executing;
  logic [PC_W-1:0] jump_target;

  // ****************************************
  // decode of the instruction in execute
  // ****************************************
  assign fsel = r.instr[FILE_AW-1:0];
  assign dest_file = r.instr[DEST_BIT];
  assign executing = (r.state == ST_EXEC);
  // status lives in the core, other addresses in the file memory
  assign fval = (fsel == STATUS_ADDR) ? r.status : mem_rd;
  assign is_dec = (r.instr & MASK_FD) == OP_DEC_SKIP;
  assign is_inc = (r.instr & MASK_FD) == OP_INC_SKIP;
  assign is_or_file = (r.instr & MASK_FD) == OP_OR_FILE;
  assign is_copy = (r.instr & MASK_FD) == OP_COPY_FILE;
  assign is_store = (r.instr & MASK_F) == OP_STORE_ACC;
  assign is_jump = (r.instr & MASK_JUMP) == OP_JUMP;
  assign is_or_lit = (r.instr & MASK_LIT) == OP_OR_LIT;
  // page bits of status over the 9-bit immediate
  assign jump_target = {r.status[PAGE_HI:PAGE_LO],
    r.instr[JUMP_K_W-1:0]};

  // ****************************************
  // result, destination and flag selection
  // ****************************************
  always_comb
  begin
    result = '0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_z = 1'b0;
    skip = 1'b0;
    if (is_dec || is_inc)
    begin
      // eight-bit sum wraps, so 255 + 1 and 1 - 1 both skip
      result = is_dec ? fval - 8'h01 : fval + 8'h01;
      wr_acc = !dest_file;
      wr_file = dest_file;
      skip = (result == 8'h00);
    end
    else if (is_or_file || is_copy)
    begin
      result = is_copy ? fval : (r.acc | fval);
      wr_acc = !dest_file;
      wr_file = dest_file;
      upd_z = 1'b1;
    end
    else if (is_or_lit)
    begin
      result = r.acc | r.instr[DATA_W-1:0];
      wr_acc = 1'b1;
      upd_z = 1'b1;
    end
    else if (is_store)
    begin
      result = r.acc;
      wr_file = 1'b1;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    n = r;
    if (ce_in)
    begin
      n.instr = instr_in;
      n.program_counter = r.program_counter + 11'h001;
      n.state = ST_EXEC;
      if (executing)
      begin
        if (wr_acc)
          n.acc = result;
        if (wr_file && fsel == STATUS_ADDR)
          n.status = result;
        if (upd_z)
          n.status[Z_BIT] = (result == 8'h00);
        if (skip)
          n.state = ST_SQUASH;
        if (is_jump)
        begin
          n.program_counter = jump_target;
          n.state = ST_SQUASH;
        end
      end
    end
  end

  // register the state
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      r <= CORE_RESET;
    else
      r <= n;
  end

  // ****************************************
  // file register space
  // ****************************************
  bobse_file_mem #(
    .AW(FILE_AW),
    .DW(DATA_W)
  ) u_file_mem (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .wr_en_in(executing && wr_file),
    .wr_addr_in(fsel),
    .wr_data_in(result),
    .rd_addr_in(instr_in[FILE_AW-1:0]),
    .rd_data_out(mem_rd)
  );

  // outputs straight from the state flops
  assign program_counter_out = r.program_counter;
  assign acc_out = r.acc;
  assign status_out = r.status;
  assign exec_instr_out = r.instr;
  assign squash_out = r.state[SQUASH_IDX];

  // ****************************************
  // checks
  // ****************************************
  a_jump_target: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_jump |=>
      program_counter_out == $past(jump_target))
    else $error("jump target wrong");

  a_jump_two_cycles: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_jump |=>
      squash_out && status_out == $past(status_out))
    else $error("jump did not squash or changed flags");

  a_dec_skip: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_dec |=>
      squash_out == ($past(fval) == 8'h01) &&
      (status_out == $past(status_out) ||
        $past(fsel) == STATUS_ADDR && $past(dest_file)))
    else $error("decrement skip wrong");

  a_inc_wrap_skip: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_inc && fval == 8'hff |=>
      squash_out ##1 (!squash_out || !$past(ce_in)))
    else $error("increment of 255 did not skip");

  a_or_literal: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_or_lit |=>
      acc_out == ($past(acc_out) | $past(r.instr[7:0])))
    else $error("or literal result wrong");

  a_zero_flag: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && upd_z |=>
      status_out[Z_BIT] == ($past(result) == 8'h00))
    else $error("zero flag wrong");

  a_store_acc: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_store && fsel != STATUS_ADDR |->
      wr_file && result == acc_out ##1 status_out == $past(status_out))
    else $error("store wrong or flags changed");

  a_dest_acc: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && (is_or_file || is_dec) && !dest_file |=>
      acc_out == $past(result))
    else $error("accumulator destination not written");

  a_copy_test: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_copy && dest_file |=>
      acc_out == $past(acc_out) &&
      status_out[Z_BIT] == ($past(fval) == 8'h00))
    else $error("copy as test wrong");

  a_or_file: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ce_in && executing && is_or_file |=>
      acc_out == ($past(dest_file) ? $past(acc_out) :
        ($past(acc_out) | $past(fval))))
    else $error("or with file wrong");

endmodule

// >>> verif/bobse_prog_mem.sv
// program memory model answering each fetch address with its word
`timescale 1ns/1ps
module bobse_prog_mem
(
  input wire logic [bobse_pkg::PC_W-1:0] addr_in,
  output logic [bobse_pkg::INSTR_W-1:0] data_out
);
  import bobse_pkg::*;

  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

  // every word is cleared before a program is loaded, so unloaded
  // words read as zero, which decodes to no_operation

  // combinational read, as a fetch port expects
  assign data_out = mem[addr_in];
endmodule

// >>> verif/test_byte_op_branch_skip_exec.sv
// self-checking bench for the skip, jump, or, store and copy core
`timescale 1ns/1ps
module test_byte_op_branch_skip_exec;
  import bobse_pkg::*;

  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [INSTR_W-1:0] instr;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] status;
  logic squash;
  logic [INSTR_W-1:0] exec_i;
  int n_fail = 0;
  int n_checks = 0;

  // 125 MHz clock
  always #4 clock_in = ~clock_in;

  bobse_prog_mem u_bobse_prog_mem (.addr_in(pc), .data_out(instr));

  bobse_core u_bobse_core (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
    .instr_in(instr), .program_counter_out(pc), .acc_out(acc),
    .status_out(status), .exec_instr_out(exec_i), .squash_out(squash)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // compare a data byte
  task automatic chk_d(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // compare a control value (program counter or squash)
  task automatic chk_c(input logic [PC_W-1:0] got,
                       input logic [PC_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // compare an instruction word
  task automatic chk_i(input logic [INSTR_W-1:0] got,
                       input logic [INSTR_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // inputs move only on falling edges
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // clear every word, then load the program from word 0
  task automatic prog(input logic [INSTR_W-1:0] w[$]);
    for (int i = 0; i < (1 << PC_W); i++)
      u_bobse_prog_mem.mem[i] = '0;
    foreach (w[i]) u_bobse_prog_mem.mem[i] = w[i];
  endtask

  // reset held six cycles; first edge after release fetches word 0
  task automatic start();
    rst_in = 1'b1;
    step(6);
    rst_in = 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // or, store and copy with flag and destination effects
  task automatic scen_logic();
    prog('{12'hd00, 12'hd81, 12'h03f, 12'h208, 12'hd42, 12'h13f,
           12'h208, 12'h23f, 12'h21f});
    start();
    step(2);
    chk_d(acc, 8'h00);
    chk_d(status, 8'h04);
    step(1);
    chk_d(acc, 8'h81);
    chk_d(status, 8'h00);
    step(1);
    chk_d(status, 8'h00);
    step(1);
    chk_d(acc, 8'h00);
    chk_d(status, 8'h04);
    step(2);
    chk_d(acc, 8'h42);
    chk_d(status, 8'h00);
    step(2);
    chk_d(acc, 8'h00);
    chk_d(status, 8'h00);
    step(1);
    chk_d(acc, 8'hc3);
    chk_c(pc, 11'h00a);
  endtask

  // decrement and increment skips, wrap and destination
  task automatic scen_skip();
    prog('{12'hd01, 12'h027, 12'h2e7, 12'hd80, 12'hdfe, 12'h028,
           12'h3c8, 12'hd40, 12'h2c7, 12'h207});
    start();
    step(4);
    chk_d(acc, 8'h01);
    chk_c(pc, 11'h004);
    chk_c({10'h000, squash}, 11'h001);
    chk_d(status, 8'h00);
    step(1);
    chk_d(acc, 8'h01);
    step(3);
    chk_d(acc, 8'h00);
    chk_d(status, 8'h00);
    chk_c({10'h000, squash}, 11'h001);
    step(1);
    chk_d(acc, 8'h00);
    step(1);
    chk_d(acc, 8'hff);
    chk_c({10'h000, squash}, 11'h000);
    step(1);
    chk_d(acc, 8'h00);
    chk_d(status, 8'h04);
  endtask

  // jumps take page bits from status and squash the next word
  task automatic scen_jump();
    prog('{12'hd20, 12'h023, 12'ha05, 12'hd40});
    u_bobse_prog_mem.mem[11'h205] = 12'hd07;
    u_bobse_prog_mem.mem[11'h206] = 12'hb05;
    u_bobse_prog_mem.mem[11'h207] = 12'hd40;
    u_bobse_prog_mem.mem[11'h305] = 12'hd80;
    start();
    step(4);
    chk_c(pc, 11'h205);
    chk_c({10'h000, squash}, 11'h001);
    chk_i(exec_i, 12'hd40);
    step(1);
    chk_d(acc, 8'h20);
    chk_d(status, 8'h20);
    step(1);
    chk_d(acc, 8'h27);
    step(1);
    chk_c(pc, 11'h305);
    step(2);
    chk_d(acc, 8'ha7);
    chk_d(status, 8'h20);
    chk_c(pc, 11'h307);
  endtask

  // clock enable low freezes core and file memory alike
  task automatic scen_freeze();
    prog('{12'hd11, 12'h3f1, 12'h211, 12'hd02});
    start();
    step(2);
    chk_d(acc, 8'h11);
    ce_in = 1'b0;
    step(3);
    chk_c(pc, 11'h002);
    chk_d(acc, 8'h11);
    chk_i(exec_i, 12'h3f1);
    ce_in = 1'b1;
    step(1);
    chk_c({10'h000, squash}, 11'h000);
    chk_d(acc, 8'h11);
    step(1);
    chk_d(acc, 8'h01);
    chk_c(pc, 11'h004);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    scen_logic();
    scen_skip();
    scen_jump();
    scen_freeze();
    wrap_up();
  end
endmodule
